// *** common/lbsrc_pkg.sv ***
// package for the local bus strobe and ready control block
package lbsrc_pkg;
    // t-states of one bus cycle
    typedef enum logic [2:0] {
        LBSRC_TI,
        LBSRC_T1,
        LBSRC_T2,
        LBSRC_T3,
        LBSRC_TW,
        LBSRC_T4
    } lbsrc_tstate_t;

    // transfer kinds requested by the core
    localparam logic [1:0] LBSRC_XFER_WORD = 2'h0;
    localparam logic [1:0] LBSRC_XFER_UPPER = 2'h1;
    localparam logic [1:0] LBSRC_XFER_LOWER = 2'h2;
    localparam logic [1:0] LBSRC_XFER_REFRESH = 2'h3;

    // queue status codes, high bit on the write-strobe pin
    localparam logic [1:0] LBSRC_QS_NONE = 2'h0;
    localparam logic [1:0] LBSRC_QS_FIRST = 2'h1;
    localparam logic [1:0] LBSRC_QS_SUBSEQ = 2'h3;
    localparam logic [1:0] LBSRC_QS_EMPTY = 2'h2;

    // reset values of the pins
    localparam logic LBSRC_RST_STROBE_N = 1'h1;
    localparam logic LBSRC_RST_ALE = 1'h0;
    // cycles after reset release before the mode pin is sampled
    localparam int LBSRC_MODE_SAMPLE_CYCLES = 1;
endpackage : lbsrc_pkg

// *** verilog/lbsrc_ready_sync.sv ***
// ready input combiner with two-flop synchroniser for the asynchronous ready
`timescale 1ns/1ps
module lbsrc_ready_sync
    import lbsrc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_async_ready,
    input wire logic i_sync_ready,
    output logic o_ready
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = i_async_ready;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= 1'h0;
            sync_r <= 1'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    // sync ready needs no synchroniser; either input ends the wait
    assign o_ready = sync_r | i_sync_ready;
endmodule : lbsrc_ready_sync

// *** verilog/lbsrc_bus_ctrl.sv ***
// local bus strobe, byte-enable, queue-status and ready control
`timescale 1ns/1ps
module lbsrc_bus_ctrl
    import lbsrc_pkg::*;
#(
    parameter bit NARROW_BUS = 1'b0
)
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // core side request
    input wire logic i_cyc_req,
    input wire logic i_cyc_write,
    input wire logic [1:0] i_cyc_xfer,
    input wire logic i_enhanced_mode,
    input wire logic [1:0] i_queue_stat,
    // pins
    input wire logic i_async_ready,
    input wire logic i_sync_ready,
    input wire logic i_queue_mode_select,
    output logic o_upper_byte_enable_n,
    output logic o_addr_bit0,
    output logic o_ale,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic o_read_strobe_oe,
    output logic o_ad_oe,
    // core side status
    output logic o_cyc_ack,
    output logic o_busy,
    output logic o_queue_mode,
    output logic [2:0] o_tstate
);
    lbsrc_tstate_t state_r;
    lbsrc_tstate_t state_nxt;
    logic write_r;
    logic write_nxt;
    logic [1:0] xfer_r;
    logic [1:0] xfer_nxt;
    logic ube_n_r;
    logic ube_n_nxt;
    logic a0_r;
    logic a0_nxt;
    logic ale_r;
    logic ale_nxt;
    logic wr_n_r;
    logic wr_n_nxt;
    logic rd_n_r;
    logic rd_n_nxt;
    logic ad_oe_r;
    logic ad_oe_nxt;
    logic ack_r;
    logic ack_nxt;
    logic qmode_r;
    logic qmode_nxt;
    logic sampled_r;
    logic sampled_nxt;
    logic ready;

    lbsrc_ready_sync u_ready (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_async_ready(i_async_ready),
        .i_sync_ready(i_sync_ready),
        .o_ready(ready)
    );

    // enable pin value for a transfer kind
    function automatic logic ube_n_of(input logic [1:0] xfer, input logic narrow,
                                      input logic enh);
        logic v;
        v = 1'b1;
        if (narrow) begin
            v = !(xfer == LBSRC_XFER_REFRESH && enh);
        end else begin
            unique case (xfer)
                LBSRC_XFER_WORD: v = 1'b0;
                LBSRC_XFER_UPPER: v = 1'b0;
                LBSRC_XFER_LOWER: v = 1'b1;
                LBSRC_XFER_REFRESH: v = 1'b1;
            endcase
        end
        return v;
    endfunction : ube_n_of

    // address bit zero for a transfer kind
    function automatic logic a0_of(input logic [1:0] xfer);
        return (xfer == LBSRC_XFER_UPPER) || (xfer == LBSRC_XFER_REFRESH);
    endfunction : a0_of

    // mode strap captured once, the cycle after release
    always_comb begin
        qmode_nxt = qmode_r;
        sampled_nxt = sampled_r;
        if (!sampled_r) begin
            qmode_nxt = !i_queue_mode_select;
            sampled_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            qmode_r <= 1'b0;
            sampled_r <= 1'b0;
        end else begin
            qmode_r <= qmode_nxt;
            sampled_r <= sampled_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        write_nxt = write_r;
        xfer_nxt = xfer_r;
        ube_n_nxt = ube_n_r;
        a0_nxt = a0_r;
        ale_nxt = 1'b0;
        wr_n_nxt = LBSRC_RST_STROBE_N;
        rd_n_nxt = LBSRC_RST_STROBE_N;
        ad_oe_nxt = 1'b0;
        ack_nxt = 1'b0;
        unique case (state_r)
            LBSRC_TI: begin
                ube_n_nxt = LBSRC_RST_STROBE_N;
                if (i_cyc_req && sampled_r) begin
                    state_nxt = LBSRC_T1;
                    write_nxt = i_cyc_write;
                    xfer_nxt = i_cyc_xfer;
                    // enable and bit zero set at T1 and held for the cycle
                    ube_n_nxt = ube_n_of(i_cyc_xfer, NARROW_BUS, i_enhanced_mode);
                    a0_nxt = a0_of(i_cyc_xfer);
                    ale_nxt = 1'b1;
                    ad_oe_nxt = 1'b1;
                end
            end
            LBSRC_T1: begin
                state_nxt = LBSRC_T2;
                // address still driven when the latch strobe falls
                ad_oe_nxt = write_r;
                wr_n_nxt = !write_r;
                // read waits one state so the bus is released first
            end
            LBSRC_T2, LBSRC_T3, LBSRC_TW: begin
                if (state_r == LBSRC_T2) begin
                    state_nxt = LBSRC_T3;
                end else if (ready) begin
                    state_nxt = LBSRC_T4;
                end else begin
                    state_nxt = LBSRC_TW;
                end
                ad_oe_nxt = write_r;
                wr_n_nxt = !write_r;
                rd_n_nxt = write_r || ad_oe_r;
                if (state_nxt == LBSRC_T4) begin
                    wr_n_nxt = 1'b1;
                    rd_n_nxt = 1'b1;
                end
            end
            LBSRC_T4: begin
                state_nxt = LBSRC_TI;
                ack_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= LBSRC_TI;
            write_r <= 1'b0;
            xfer_r <= LBSRC_XFER_WORD;
            ube_n_r <= LBSRC_RST_STROBE_N;
            a0_r <= 1'b0;
            ale_r <= LBSRC_RST_ALE;
            wr_n_r <= LBSRC_RST_STROBE_N;
            rd_n_r <= LBSRC_RST_STROBE_N;
            ad_oe_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            write_r <= write_nxt;
            xfer_r <= xfer_nxt;
            ube_n_r <= ube_n_nxt;
            a0_r <= a0_nxt;
            ale_r <= ale_nxt;
            wr_n_r <= wr_n_nxt;
            rd_n_r <= rd_n_nxt;
            ad_oe_r <= ad_oe_nxt;
            ack_r <= ack_nxt;
        end
    end

    // queue mode reuses the latch and write pins for status
    assign o_ale = qmode_r ? i_queue_stat[0] : ale_r;
    assign o_write_strobe_n = qmode_r ? i_queue_stat[1] : wr_n_r;
    // pin is an input strap until sampled, then driven only in strobe mode
    assign o_read_strobe_n = rd_n_r;
    assign o_read_strobe_oe = sampled_r && !qmode_r;
    assign o_upper_byte_enable_n = ube_n_r;
    assign o_addr_bit0 = a0_r;
    assign o_ad_oe = ad_oe_r;
    assign o_cyc_ack = ack_r;
    assign o_busy = state_r != LBSRC_TI;
    assign o_queue_mode = qmode_r;
    assign o_tstate = state_r;
endmodule : lbsrc_bus_ctrl

// *** testbench/lbsrc_mem_model.sv ***
// memory and i/o partner: ready answers and mode strap
`timescale 1ns/1ps
module lbsrc_mem_model
    import lbsrc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [2:0] i_tstate,
    input wire logic [1:0] i_waits,
    input wire logic i_use_async,
    input wire logic i_qmode,
    output logic o_sync_ready,
    output logic o_async_ready,
    output logic o_strap
);
    logic [1:0] cnt_r;
    logic in_data;
    assign in_data = i_tstate == LBSRC_T3 || i_tstate == LBSRC_TW;
    always_ff @(posedge i_ref_clk) begin
        cnt_r <= in_data ? cnt_r + 2'h1 : 2'h0;
    end
    assign o_sync_ready = !i_use_async && in_data && cnt_r == i_waits;
    // changed only at clock edges by the bench, low when unused
    assign o_async_ready = i_use_async;
    assign o_strap = !i_qmode;
endmodule : lbsrc_mem_model

// *** testbench/lbsrc_bus_checker.sv ***
// assertions on the bus control pins
`timescale 1ns/1ps
module lbsrc_bus_chk
    import lbsrc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_cyc_xfer,
    input wire logic [1:0] i_queue_stat,
    input wire logic i_async_ready,
    input wire logic i_sync_ready,
    input wire logic o_upper_byte_enable_n,
    input wire logic o_addr_bit0,
    input wire logic o_ale,
    input wire logic o_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_read_strobe_oe,
    input wire logic o_ad_oe,
    input wire logic o_cyc_ack,
    input wire logic o_queue_mode,
    input wire logic [2:0] o_tstate
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_finish;
        o_tstate == LBSRC_T4 ##1 o_cyc_ack;
    endsequence
    ale_one_cycle_a: assert property (o_ale && !o_queue_mode |=> !o_ale)
        else $error("ale too long");
    enc_at_t1_a: assert property (o_tstate == LBSRC_T1 |->
        {o_upper_byte_enable_n, o_addr_bit0} == $past(i_cyc_xfer)) else $error("bad encoding");
    ube_hold_a: assert property (o_tstate inside {LBSRC_T2, LBSRC_T3, LBSRC_TW, LBSRC_T4}
        |-> $stable({o_upper_byte_enable_n, o_addr_bit0})) else $error("enable moved");
    rd_after_float_a: assert property ($fell(o_read_strobe_n) && !o_queue_mode
        |-> !o_ad_oe && !$past(o_ad_oe) && o_tstate == LBSRC_T3) else $error("read early");
    qs_map_a: assert property (o_queue_mode
        |-> {o_write_strobe_n, o_ale} == i_queue_stat) else $error("queue code");
    strap_oe_a: assert property ($past(i_arst_n)
        |-> o_read_strobe_oe != o_queue_mode) else $error("read pin drive");
    sync_end_a: assert property (o_tstate == LBSRC_T3 && i_sync_ready |=> s_finish)
        else $error("no end on ready");
    wait_ins_a: assert property (!i_async_ready [*3] ##0
        (o_tstate == LBSRC_T3 && !i_sync_ready) |=> o_tstate == LBSRC_TW) else $error("no wait");
endmodule : lbsrc_bus_chk

bind lbsrc_bus_ctrl lbsrc_bus_chk u_chk(.i_ref_clk, .i_arst_n, .i_cyc_xfer, .i_queue_stat,
    .i_async_ready, .i_sync_ready, .o_upper_byte_enable_n, .o_addr_bit0, .o_ale,
    .o_write_strobe_n, .o_read_strobe_n, .o_read_strobe_oe, .o_ad_oe, .o_cyc_ack,
    .o_queue_mode, .o_tstate);

// *** testbench/tb_top.sv ***
// self-checking bench for the bus control block
`timescale 1ns/1ps
module tb_top;
    import lbsrc_pkg::*;
    logic clk = 1'b0;
    // left unknown so the first drive low is a falling edge for the async reset
    logic rst_n;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic ua = 1'b0;
    logic qm = 1'b0;
    logic [1:0] xf = 2'h0;
    logic [1:0] qs = 2'h0;
    logic [1:0] wt = 2'h0;
    logic ar, sr, strap, ube_n, a0, ale, wr_n, rd_n, rd_oe, ack, qmode, busy;
    logic [2:0] ts;
    int errors = 0;
    int n_compared = 0;
    initial forever #10 clk = ~clk;
    lbsrc_mem_model u_mem(.i_ref_clk(clk), .i_tstate(ts), .i_waits(wt), .i_use_async(ua),
        .i_qmode(qm), .o_sync_ready(sr), .o_async_ready(ar), .o_strap(strap));
    lbsrc_bus_ctrl uut(.i_ref_clk(clk), .i_arst_n(rst_n), .i_cyc_req(req), .i_cyc_write(wr),
        .i_cyc_xfer(xf), .i_enhanced_mode(1'b1), .i_queue_stat(qs), .i_async_ready(ar),
        .i_sync_ready(sr), .i_queue_mode_select(rd_oe ? rd_n : strap),
        .o_upper_byte_enable_n(ube_n), .o_addr_bit0(a0), .o_ale(ale), .o_write_strobe_n(wr_n),
        .o_read_strobe_n(rd_n), .o_read_strobe_oe(rd_oe), .o_ad_oe(), .o_cyc_ack(ack),
        .o_busy(busy), .o_queue_mode(qmode), .o_tstate(ts));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic q);
        qm <= q;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({ale, wr_n, rd_oe, ube_n}, 8'h05);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({qmode, rd_oe}, {6'h00, q, !q});
    endtask : do_reset
    task automatic bus_cyc(input logic w, input logic [1:0] x, input logic [1:0] n, input logic a);
        int t, nale, nrd, nwr;
        logic done;
        t = 0;
        nale = 0;
        nrd = 0;
        nwr = 0;
        @(posedge clk);
        #1 chk(8'(busy), 8'h00);
        @(posedge clk);
        {wr, xf, wt, ua, req} <= {w, x, n, a, 1'b1};
        @(posedge clk);
        req <= 1'b0;
        do begin
            #1 t++;
            nale += ale;
            nrd += !rd_n;
            nwr += !wr_n;
            done = ack;
            if (ts == LBSRC_T1) chk({ube_n, a0}, x);
            if (t == 1) chk(8'(busy), 8'h01);
            @(posedge clk);
        end while (!done && t < 20);
        chk(8'(t), 8'(5 + n));
        chk(8'(nale), 8'h01);
        chk(8'(nrd), w ? 8'h00 : 8'(1 + n));
        chk(8'(nwr), w ? 8'(2 + n) : 8'h00);
    endtask : bus_cyc
    task automatic queue_scn;
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            qs <= 2'(i);
            #1 chk({wr_n, ale}, 8'(i));
        end
    endtask : queue_scn
    task automatic conclude;
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) bus_cyc(1'b0, 2'(i), 2'(i), 1'b0);
        for (int i = 0; i < 4; i++) bus_cyc(1'b1, 2'(i), 2'h2, 1'b0);
        bus_cyc(1'b0, 2'h1, 2'h0, 1'b1);
        queue_scn;
        conclude;
    end
    initial begin
        #20us;
        errors++;
        conclude;
    end
endmodule : tb_top
